/* design/ftp_ctrl.sv */
// Programmer that trims the switch by pulsing its supply pin
`timescale 1ns/1ps
module ftp_ctrl import ftp_pkg::*; #(
    parameter int CYC_OFF = FTP_CYC_OFF,
    parameter int CYC_PWRUP = FTP_CYC_PWRUP,
    parameter int CYC_PULSE = FTP_CYC_PULSE,
    parameter int CYC_GAP = FTP_CYC_GAP,
    parameter int CYC_BURN = FTP_CYC_BURN,
    parameter int CYC_SETTLE = FTP_CYC_SETTLE,
    parameter int CYC_CHECK = FTP_CYC_CHECK
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic [2:0] i_cmd,
    input wire logic [3:0] i_key,
    input wire logic [5:0] i_code,
    input wire logic i_marginal,
    output logic [1:0] o_vcc_level,
    output logic o_busy,
    output logic o_done,
    output logic o_refused,
    output logic o_marginal,
    output logic o_locked
);
    ftp_state_e state_q, state_d;
    ftp_seg_e seg_q, seg_d;
    logic [5:0] cnt_q, cnt_d;
    logic [5:0] addr_q, addr_d;
    logic [3:0] key_q, key_d;
    logic blow_q, blow_d, check_q, check_d, lock_q, lock_d;
    logic [1:0] lvl_q, lvl_d;
    logic tmr_go;
    logic [FTP_TMR_W-1:0] tmr_len;
    logic tmr_done;
    logic done_q, done_d, ref_q, ref_d, marg_q, marg_d, locked_q, locked_d;
    logic s1_q, s2_q, s3_q, sense_q;
    logic busy_q;

    // Supply current sense comes from an analog comparator, so synchronise
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            sense_q <= 1'b0;
        end else begin
            s1_q <= i_marginal;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) sense_q <= s3_q;
        end
    end

    wire logic is_blow = (i_cmd == FTP_CMD_BLOW) || (i_cmd == FTP_CMD_LOCK);
    wire logic is_chk = (i_cmd == FTP_CMD_CHK_LO) || (i_cmd == FTP_CMD_CHK_HI);
    wire logic bad_cmd = (i_cmd > FTP_CMD_LOCK);
    // One-hot addressing only reaches six bits
    wire logic bad_bit = (i_cmd == FTP_CMD_BLOW) && (i_code > FTP_MAX_BIT);
    // Fuse check stays legal after lock, nothing else does
    wire logic lock_blk = locked_q && !is_chk;
    wire logic accept = i_start && (state_q == FTP_S_IDLE);
    wire logic refuse = bad_cmd || bad_bit || lock_blk;
    wire logic [5:0] chk_code = (i_cmd == FTP_CMD_CHK_HI) ? FTP_CODE_CHK_HI : FTP_CODE_CHK_LO;
    wire logic [5:0] cmd_code = (i_cmd == FTP_CMD_LOCK) ? FTP_LOCK_BIT :
                                 is_chk ? chk_code : i_code;
    wire logic [3:0] cmd_key = (i_cmd == FTP_CMD_LOCK) ? FTP_KEY_LOCK :
                                is_chk ? FTP_KEY_CHECK : i_key;
    // Blow addresses bit n with n+1 mid pulses, try sends the code itself
    wire logic [5:0] addr_cnt = blow_q ? addr_q + 6'h01 : addr_q;

    always_comb begin
        state_d = state_q;
        seg_d = seg_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        key_d = key_q;
        blow_d = blow_q;
        check_d = check_q;
        lock_d = lock_q;
        lvl_d = lvl_q;
        tmr_go = 1'b0;
        tmr_len = '0;
        done_d = 1'b0;
        ref_d = 1'b0;
        marg_d = marg_q;
        locked_d = locked_q;
        case (state_q)
            FTP_S_IDLE: begin
                if (accept && refuse) begin
                    ref_d = 1'b1;
                end else if (accept) begin
                    key_d = cmd_key;
                    addr_d = cmd_code;
                    blow_d = is_blow;
                    check_d = is_chk;
                    lock_d = (i_cmd == FTP_CMD_LOCK);
                    // Every sequence starts from a power cycle
                    lvl_d = FTP_LVL_OFF;
                    tmr_go = 1'b1;
                    tmr_len = FTP_TMR_W'(CYC_OFF);
                    state_d = FTP_S_OFF;
                end
            end
            FTP_S_OFF: if (tmr_done) begin
                lvl_d = FTP_LVL_NORM;
                tmr_go = 1'b1;
                tmr_len = FTP_TMR_W'(CYC_PWRUP);
                state_d = FTP_S_PWRUP;
            end
            FTP_S_PWRUP: if (tmr_done) begin
                seg_d = FTP_SEG_KEY;
                cnt_d = {2'h0, key_q};
                state_d = FTP_S_NEXT;
            end
            FTP_S_NEXT: begin
                tmr_go = 1'b1;
                if (cnt_q != 6'h00) begin
                    cnt_d = cnt_q - 6'h01;
                    lvl_d = FTP_LVL_MID;
                    tmr_len = FTP_TMR_W'(CYC_PULSE);
                    state_d = FTP_S_MID;
                end else if (seg_q != FTP_SEG_ADDR) begin
                    lvl_d = FTP_LVL_HIGH;
                    tmr_len = FTP_TMR_W'(CYC_PULSE);
                    state_d = FTP_S_HIGH;
                end else if (blow_q) begin
                    lvl_d = FTP_LVL_HIGH;
                    tmr_len = FTP_TMR_W'(CYC_BURN);
                    state_d = FTP_S_BURN;
                end else begin
                    // Try codes take effect at once; try and check both wait CYC_CHECK in settle before done
                    tmr_len = FTP_TMR_W'(CYC_CHECK);
                    state_d = FTP_S_SETTLE;
                end
            end
            FTP_S_MID, FTP_S_HIGH: if (tmr_done) begin
                lvl_d = FTP_LVL_NORM;
                tmr_go = 1'b1;
                tmr_len = FTP_TMR_W'(CYC_GAP);
                state_d = FTP_S_GAP;
                if (state_q == FTP_S_HIGH && seg_q == FTP_SEG_KEY && blow_q) begin
                    seg_d = FTP_SEG_MODE;
                    cnt_d = {2'h0, FTP_BLOW_KEY_MIDS};
                end else if (state_q == FTP_S_HIGH) begin
                    seg_d = FTP_SEG_ADDR;
                    cnt_d = addr_cnt;
                end
            end
            FTP_S_GAP: if (tmr_done) state_d = FTP_S_NEXT;
            FTP_S_BURN: if (tmr_done) begin
                lvl_d = FTP_LVL_NORM;
                tmr_go = 1'b1;
                tmr_len = FTP_TMR_W'(CYC_SETTLE);
                state_d = FTP_S_SETTLE;
            end
            FTP_S_SETTLE: if (tmr_done) begin
                done_d = 1'b1;
                state_d = FTP_S_IDLE;
                if (blow_q) begin
                    lvl_d = FTP_LVL_OFF;
                    if (lock_q) locked_d = 1'b1;
                end
                if (check_q) marg_d = sense_q;
            end
            default: begin
                lvl_d = FTP_LVL_OFF;
                state_d = FTP_S_IDLE;
            end
        endcase
    end

    ftp_timer #(
        .W(FTP_TMR_W)
    ) u_timer (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_start(tmr_go),
        .i_len(tmr_len),
        .o_done(tmr_done)
    );

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= FTP_S_IDLE;
            seg_q <= FTP_SEG_KEY;
            cnt_q <= 6'h00;
            addr_q <= 6'h00;
            key_q <= 4'h0;
            {blow_q, check_q, lock_q} <= 3'h0;
            lvl_q <= FTP_LVL_OFF;
            {done_q, ref_q, marg_q, locked_q} <= 4'h0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            seg_q <= seg_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            key_q <= key_d;
            {blow_q, check_q, lock_q} <= {blow_d, check_d, lock_d};
            lvl_q <= lvl_d;
            {done_q, ref_q, marg_q, locked_q} <= {done_d, ref_d, marg_d, locked_d};
            // Busy from the next state, so the pin carries no decode glitch
            busy_q <= (state_d != FTP_S_IDLE);
        end
    end

    assign o_vcc_level = lvl_q;
    assign o_busy = busy_q;
    assign o_done = done_q;
    assign o_refused = ref_q;
    assign o_marginal = marg_q;
    assign o_locked = locked_q;

    // Helper counters watched only by the checks below
    logic [1:0] burns_q;
    logic [3:0] mode_mids_q;
    logic [FTP_TMR_W-1:0] settle_el_q;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            burns_q <= 2'h0;
            mode_mids_q <= 4'h0;
            settle_el_q <= '0;
        end else begin
            if (lvl_q == FTP_LVL_OFF) burns_q <= 2'h0;
            else if (state_d == FTP_S_BURN && state_q != FTP_S_BURN) burns_q <= burns_q + 2'h1;
            if (seg_q != FTP_SEG_MODE) mode_mids_q <= 4'h0;
            else if (state_d == FTP_S_MID && state_q != FTP_S_MID)
                mode_mids_q <= mode_mids_q + 4'h1;
            settle_el_q <= (state_q == FTP_S_SETTLE) ? settle_el_q + 1'b1 : '0;
        end
    end

    property p_one_burn;
        @(posedge i_clk) disable iff (!i_rstn) (lvl_q != FTP_LVL_OFF) |-> (burns_q <= 2'h1);
    endproperty
    a_one_burn: assert property (p_one_burn) else $error("second burn without power cycle");
    property p_blow_key;
        @(posedge i_clk) disable iff (!i_rstn)
            (seg_q == FTP_SEG_MODE && seg_d == FTP_SEG_ADDR) |-> (mode_mids_q == 4'h9);
    endproperty
    a_blow_key: assert property (p_blow_key) else $error("blow key not nine mids");
    property p_lock_seq;
        @(posedge i_clk) disable iff (!i_rstn) (accept && !refuse && i_cmd == FTP_CMD_LOCK)
            |=> (key_q == 4'h7 && addr_q == 6'h03 && blow_q && state_q == FTP_S_OFF);
    endproperty
    a_lock_seq: assert property (p_lock_seq) else $error("lock sequence set up wrong");
    property p_settle;
        @(posedge i_clk) disable iff (!i_rstn)
            (state_q == FTP_S_SETTLE && blow_q && lvl_d == FTP_LVL_OFF)
            |-> (settle_el_q >= FTP_TMR_W'(CYC_SETTLE));
    endproperty
    a_settle: assert property (p_settle) else $error("power removed before settle");
    property p_refuse_locked;
        @(posedge i_clk) disable iff (!i_rstn)
            (accept && locked_q && (i_cmd == FTP_CMD_BLOW || i_cmd == FTP_CMD_TRY))
            |=> (o_refused && !o_busy);
    endproperty
    a_refuse_locked: assert property (p_refuse_locked) else $error("programming after lock");
    property p_burn_high;
        @(posedge i_clk) disable iff (!i_rstn)
            $rose(state_q == FTP_S_BURN) |-> (o_vcc_level == FTP_LVL_HIGH)[*8];
    endproperty
    a_burn_high: assert property (p_burn_high) else $error("burn pulse dropped early");
    property p_no_burn_try;
        @(posedge i_clk) disable iff (!i_rstn) (state_q == FTP_S_BURN) |-> blow_q;
    endproperty
    a_no_burn_try: assert property (p_no_burn_try) else $error("burn in try sequence");
    property p_bad_bit;
        @(posedge i_clk) disable iff (!i_rstn)
            (accept && i_cmd == FTP_CMD_BLOW && i_code > 6'h05) |=> ##[0:2] o_refused;
    endproperty
    a_bad_bit: assert property (p_bad_bit) else $error("out of range bit accepted");
    c_lock: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(o_locked));
    c_check: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(o_marginal));
    c_refuse: cover property (@(posedge i_clk) disable iff (!i_rstn) o_refused);
endmodule

/* design/ftp_pkg.sv */
// Constants, codes and states for the fuse trim programmer
package ftp_pkg;
    localparam int FTP_CLK_NS = 20;
    // Pulse and wait times in microseconds
    localparam int FTP_T_OFF_US = 1000;
    localparam int FTP_T_PWRUP_US = 1000;
    localparam int FTP_T_PULSE_US = 20;
    localparam int FTP_T_GAP_US = 20;
    localparam int FTP_T_BURN_US = 100;
    localparam int FTP_T_SETTLE_US = 200;
    localparam int FTP_T_CHECK_US = 100;
    // Least times, rounded up to whole cycles
    localparam int FTP_CYC_OFF = (FTP_T_OFF_US * 1000 + FTP_CLK_NS - 1) / FTP_CLK_NS;
    localparam int FTP_CYC_PWRUP = (FTP_T_PWRUP_US * 1000 + FTP_CLK_NS - 1) / FTP_CLK_NS;
    localparam int FTP_CYC_PULSE = (FTP_T_PULSE_US * 1000 + FTP_CLK_NS - 1) / FTP_CLK_NS;
    localparam int FTP_CYC_GAP = (FTP_T_GAP_US * 1000 + FTP_CLK_NS - 1) / FTP_CLK_NS;
    localparam int FTP_CYC_BURN = (FTP_T_BURN_US * 1000 + FTP_CLK_NS - 1) / FTP_CLK_NS;
    localparam int FTP_CYC_SETTLE = (FTP_T_SETTLE_US * 1000 + FTP_CLK_NS - 1) / FTP_CLK_NS;
    localparam int FTP_CYC_CHECK = (FTP_T_CHECK_US * 1000 + FTP_CLK_NS - 1) / FTP_CLK_NS;
    localparam int FTP_TMR_W = 20;
    // Supply pin levels
    localparam logic [1:0] FTP_LVL_OFF = 2'h0;
    localparam logic [1:0] FTP_LVL_NORM = 2'h1;
    localparam logic [1:0] FTP_LVL_MID = 2'h2;
    localparam logic [1:0] FTP_LVL_HIGH = 2'h3;
    // User commands
    localparam logic [2:0] FTP_CMD_TRY = 3'h0;
    localparam logic [2:0] FTP_CMD_BLOW = 3'h1;
    localparam logic [2:0] FTP_CMD_CHK_LO = 3'h2;
    localparam logic [2:0] FTP_CMD_CHK_HI = 3'h3;
    localparam logic [2:0] FTP_CMD_LOCK = 3'h4;
    // Keys and codes
    localparam logic [3:0] FTP_KEY_CHECK = 4'h7;
    localparam logic [3:0] FTP_KEY_LOCK = 4'h7;
    localparam logic [3:0] FTP_BLOW_KEY_MIDS = 4'h9;
    localparam logic [5:0] FTP_LOCK_BIT = 6'h03;
    localparam logic [5:0] FTP_MAX_BIT = 6'h05;
    localparam logic [5:0] FTP_CODE_CHK_LO = 6'h07;
    localparam logic [5:0] FTP_CODE_CHK_HI = 6'h0f;
    typedef enum logic [1:0] {FTP_SEG_KEY, FTP_SEG_MODE, FTP_SEG_ADDR} ftp_seg_e;
    typedef enum logic [3:0] {
        FTP_S_IDLE, FTP_S_OFF, FTP_S_PWRUP, FTP_S_NEXT, FTP_S_MID,
        FTP_S_HIGH, FTP_S_GAP, FTP_S_BURN, FTP_S_SETTLE
    } ftp_state_e;
endpackage

/* design/ftp_timer.sv */
// Down-counting interval timer for pulse and wait lengths
`timescale 1ns/1ps
module ftp_timer import ftp_pkg::*; #(
    parameter int W = FTP_TMR_W
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic [W-1:0] i_len,
    output logic o_done
);
    logic [W-1:0] cnt_q;
    logic done_q;
    wire logic last = (cnt_q == {{(W-1){1'b0}}, 1'b1});

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else if (i_start) begin
            cnt_q <= i_len;
            done_q <= 1'b0;
        end else begin
            if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
            done_q <= last;
        end
    end

    assign o_done = done_q;
endmodule

/* tb/ftp_dev_model.sv */
// Behavioural switch that decodes supply pulses into trim and fuse state
`timescale 1ns/1ps
module ftp_dev_model #(
    parameter int CYC_BURN = 10,
    parameter int CYC_SETTLE = 8,
    parameter int HYS = 3
) (
    input wire logic i_clk,
    input wire logic [1:0] i_level,
    input wire logic i_weak_intact,
    input wire logic i_weak_blown,
    output logic o_marginal,
    output logic [5:0] o_field,
    output logic [5:0] o_trim_fuse,
    output logic [5:0] o_lock_fuse,
    output logic o_viol
);
    logic [1:0] lv_q = 2'h0;
    logic [5:0] fuse [0:15] = '{default: 6'h00};
    logic [3:0] key_q = 4'h0;
    logic [1:0] seg_q = 2'h0;
    logic blow_q = 1'b0;
    logic burned_q = 1'b0;
    logic [5:0] cd;
    logic [5:0] field_q = 6'h00;
    logic viol_q = 1'b0;
    int mids = 0;
    int hcnt = 0;
    int settle = 0;
    int rel_thr;
    wire locked = fuse[7][3];
    wire chk_on = (i_level == 2'h1) && (seg_q == 2'h1) && !blow_q && (key_q == 4'h7);
    assign o_marginal = chk_on && ((mids == 15 && i_weak_blown) || (mids == 7 && i_weak_intact));
    assign o_trim_fuse = fuse[0];
    assign o_lock_fuse = fuse[7];
    // Hysteresis is fixed, never touched by a sequence
    assign rel_thr = int'(o_field) - HYS;
    assign o_field = field_q;
    assign o_viol = viol_q;
    always @(posedge i_clk) begin
        if (i_level == 2'h0) begin
            // Power loss too soon after a burn may leave a half-blown fuse
            if (burned_q && settle < CYC_SETTLE) viol_q = 1'b1;
            key_q = 4'h0;
            seg_q = 2'h0;
            blow_q = 1'b0;
            burned_q = 1'b0;
            mids = 0;
            field_q = 6'h00;
        end
        if (lv_q == 2'h2 && i_level != 2'h2) mids++;
        if (i_level == 2'h3) hcnt++;
        if (i_level == 2'h1 && burned_q) settle++;
        if (lv_q == 2'h3 && i_level != 2'h3) begin
            if (seg_q == 2'h0) begin
                key_q = 4'(mids);
                mids = 0;
                seg_q = 2'h1;
            end else if (seg_q == 2'h1 && mids == 9) begin
                blow_q = 1'b1;
                mids = 0;
                seg_q = 2'h2;
            end else if (seg_q == 2'h2 && hcnt >= CYC_BURN) begin
                if (burned_q) viol_q = 1'b1;
                if (!locked && mids >= 1 && mids <= 6) fuse[key_q][mids-1] = 1'b1;
                burned_q = 1'b1;
                settle = 0;
            end
            hcnt = 0;
        end
        cd = (mids > 63) ? 6'h3f : 6'(mids);
        if (seg_q == 2'h1 && !blow_q && !locked && key_q < 4'h2) begin
            field_q = (key_q == 4'h1) ? ~cd : cd;
        end
        lv_q = i_level;
    end
endmodule

/* tb/tb.sv */
// Self-checking bench for the fuse trim programmer
`timescale 1ns/1ps
module tb import ftp_pkg::*;;
    typedef struct packed {logic refd; logic chk; logic mg;} ftp_exp_s;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    logic [2:0] cmd = 3'h0;
    logic [3:0] key = 4'h0;
    logic [5:0] code = 6'h00;
    logic wi = 1'b0;
    logic wb = 1'b0;
    logic marg_in;
    logic [1:0] lvl;
    logic busy, done, refused, marg, locked, viol;
    logic [5:0] field, trim_f, lock_f, cd, b, exp_trim;
    int seed = 32'h55dc;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    ftp_exp_s exp_q[$];
    ftp_exp_s e_w;
    always #10 clk = ~clk;
    // Burn and settle keep their full lengths; the model's minimums are far below them
    ftp_ctrl #(.CYC_OFF(6), .CYC_PWRUP(6), .CYC_PULSE(4), .CYC_GAP(4),
        .CYC_CHECK(8)) ftp_ctrl_i (.i_clk(clk), .i_rstn(rstn),
        .i_start(start), .i_cmd(cmd), .i_key(key), .i_code(code), .i_marginal(marg_in),
        .o_vcc_level(lvl), .o_busy(busy), .o_done(done), .o_refused(refused),
        .o_marginal(marg), .o_locked(locked));
    ftp_dev_model ftp_dev_model_i (.i_clk(clk),
        .i_level(lvl), .i_weak_intact(wi), .i_weak_blown(wb), .o_marginal(marg_in),
        .o_field(field), .o_trim_fuse(trim_f), .o_lock_fuse(lock_f), .o_viol(viol));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Each request is held for one edge, then the bench waits for the answer
    task automatic run(input logic [2:0] c, input logic [3:0] k, input logic [5:0] d,
        input logic rf, input logic ck, input logic mg);
        exp_q.push_back({rf, ck, mg});
        @(negedge clk);
        start = 1'b1;
        cmd = c;
        key = k;
        code = d;
        @(negedge clk);
        start = 1'b0;
        check(8'(busy), 8'(!rf), "busy after request");
        while (done !== 1'b1 && refused !== 1'b1) @(negedge clk);
        @(negedge clk);
    endtask
    always @(negedge clk) begin
        if (done === 1'b1 || refused === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(8'h01, 8'h00, "unexpected answer");
            end else begin
                e_w = exp_q.pop_front();
                check(8'(refused), 8'(e_w.refd), "refusal");
                if (e_w.chk) check(8'(marg), 8'(e_w.mg), "marginal flag");
            end
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            $display("[ERR] t=%0t run did not finish", $time);
            n_fail++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            key = 4'(i % 2);
            cd = (i < 2) ? 6'h00 : (i < 4) ? 6'h3f : 6'($random(seed));
            run(FTP_CMD_TRY, 4'(i % 2), cd, 1'b0, 1'b0, 1'b0);
            check(8'(field), 8'(6'((i % 2 == 1) ? ~cd : cd)), "trim field");
        end
        $display("test try_trim done");
        exp_trim = 6'h00;
        for (int j = 0; j < 3; j++) begin
            b = (j == 0) ? 6'h02 : (j == 1) ? 6'h00 : 6'({$random(seed)} % 6);
            run(FTP_CMD_BLOW, 4'h0, b, 1'b0, 1'b0, 1'b0);
            exp_trim = exp_trim | (6'h01 << b);
            check(8'(trim_f), 8'(exp_trim), "trim fuses");
        end
        $display("test blow_bits done");
        for (int c = 5; c < 8; c++) run(3'(c), 4'h0, 6'h00, 1'b1, 1'b0, 1'b0);
        run(FTP_CMD_BLOW, 4'h0, 6'h06, 1'b1, 1'b0, 1'b0);
        check(8'(trim_f), 8'(exp_trim), "trim after refusal");
        $display("test refusals done");
        for (int i = 0; i < 4; i++) begin
            wi = i[0];
            wb = i[1];
            run(FTP_CMD_CHK_LO, 4'h0, 6'h00, 1'b0, 1'b1, i[0]);
            run(FTP_CMD_CHK_HI, 4'h0, 6'h00, 1'b0, 1'b1, i[1]);
        end
        $display("test fuse_check done");
        run(FTP_CMD_LOCK, 4'h0, 6'h00, 1'b0, 1'b0, 1'b0);
        check(8'(lock_f), 8'h08, "lock fuse");
        check(8'(locked), 8'h01, "locked flag");
        run(FTP_CMD_TRY, 4'h0, 6'h05, 1'b1, 1'b0, 1'b0);
        run(FTP_CMD_BLOW, 4'h0, 6'h01, 1'b1, 1'b0, 1'b0);
        wb = 1'b1;
        run(FTP_CMD_CHK_HI, 4'h0, 6'h00, 1'b0, 1'b1, 1'b1);
        check(8'(trim_f), 8'(exp_trim), "trim after lock");
        check(8'(viol), 8'h00, "supply timing");
        check(8'(exp_q.size()), 8'h00, "answers missing");
        $display("test lock done");
        final_report();
    end
endmodule
